// *** sync_window_regs.sv ***
// vertical window, sync source and gain set 0 registers with datapath
`timescale 1ns/1ps
`include "sync_window_defs.svh"

module sync_window_regs (
  input wire logic clk, // 10 MHz pixel and bus clock
  input wire logic rstn, // asynchronous reset, active low
  input wire logic ce, // clock enable, freezes all state when low
  // --------
  // classic wishbone slave
  // --------
  input wire logic [7:0] adr_i, // byte address
  input wire logic [31:0] dat_i, // write data
  output logic [31:0] dat_o, // read data
  input wire logic we_i, // write enable
  input wire logic [3:0] sel_i, // byte selects
  input wire logic cyc_i, // cycle
  input wire logic stb_i, // strobe
  output logic ack_o, // acknowledge pulse
  // --------
  // pins and video
  // --------
  input wire logic regSetSelPin, // high selects buffered set 1
  input wire logic extHsyncPin, // external horizontal sync pin
  input wire logic extVsyncPin, // external vertical sync pin
  input wire sync_window_pkg::sync_pair_type digitizedSync, // digitized
  input wire sync_window_pkg::sync_pair_type d1Trs, // D1 stream marks
  input wire sync_window_pkg::sync_pair_type d2Trs, // D2 stream marks
  input wire logic lineStart, // pulse at each line start
  input wire logic eqDone, // pulse at end of last equalizing pulse
  input wire logic vblankEnd, // pulse at end of vertical blanking
  input wire logic newFieldIn, // raw frame detect pulse
  input wire logic [9:0] secondaryVideoIn, // secondary video reference
  input wire logic [9:0] lpfSyncIn, // low pass filter output
  input wire logic [9:0] msyncIn, // mixed sync sample
  input wire sync_window_pkg::yuv_type combIn, // full decoder output
  input wire sync_window_pkg::yuv_type simpleIn, // simple decoder output
  input wire logic [9:0] rawIn, // unprocessed input video
  input wire sync_window_pkg::gain_set_type gainSet1, // buffered set 1
  output sync_window_pkg::yuv_type videoOut, // processed video
  output logic [9:0] msyncOut, // scaled mixed sync
  output logic [9:0] sepInput, // mixed sync separator input
  output sync_window_pkg::sync_pair_type syncGenOut, // to pulse generator
  output logic newFieldOut, // delayed frame detect pulse
  output logic lineOffset // decoder state machine 1H offset
);

  // --------
  // register storage
  // --------
  logic [7:0] vertWindowControl;
  logic [7:0] syncSourceSelect;
  logic [7:0] mixedSyncGainLow;
  logic [7:0] lumaGainLow;
  logic [7:0] uGainLow;
  logic [7:0] vGainLow;
  logic [7:0] gainHighBits;
  logic [7:0] mixedSyncGainHigh;

  logic [4:0] vert_window_lines;
  logic in_window_action;
  logic post_window_action;
  logic [1:0] field_detect_delay;
  logic [1:0] sync_gen_source_sel;
  logic msync_sep_source;
  logic state_machine_line_offset;

  assign vert_window_lines =
    vertWindowControl[`VWC_LINES_MSB:`VWC_LINES_LSB];
  assign in_window_action = vertWindowControl[`VWC_IN_BIT];
  assign post_window_action = vertWindowControl[`VWC_POST_BIT];
  assign field_detect_delay =
    syncSourceSelect[`SSS_DLY_MSB:`SSS_DLY_LSB];
  assign sync_gen_source_sel =
    syncSourceSelect[`SSS_SRC_MSB:`SSS_SRC_LSB];
  assign msync_sep_source = syncSourceSelect[`SSS_SEP_BIT];
  assign state_machine_line_offset = syncSourceSelect[`SSS_OFS_BIT];

  // --------
  // pin synchronisers
  // --------
  logic [2:0] pinMeta;
  logic [2:0] pinSync;

  // two flops per pin; only the second stage feeds logic
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pinMeta <= 3'h0;
      pinSync <= 3'h0;
    end else if (ce) begin
      pinMeta <= {regSetSelPin, extVsyncPin, extHsyncPin};
      pinSync <= pinMeta;
    end
  end

  logic setSelect;
  sync_window_pkg::sync_pair_type extSync;
  assign setSelect = pinSync[2];
  assign extSync.h = pinSync[0];
  assign extSync.v = pinSync[1];

  // --------
  // wishbone decode
  // --------
  logic [5:0] regIndex;
  logic busReq;
  logic wrByte0;

  assign regIndex = adr_i[7:2];
  // ack is high for one cycle and blocks the request in that cycle; a request still held after it is taken again
  assign busReq = cyc_i && stb_i && !ack_o;
  assign wrByte0 = busReq && we_i && sel_i[0];

  // a byte enables on lane 0 only; other lanes hold no bits
  function automatic logic [7:0] masked(input logic [7:0] data,
                                        input logic [7:0] mask);
    masked = data & mask;
  endfunction : masked

  // single-cycle answer for every address, mapped or not
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ack_o <= 1'b0;
    end else if (ce) begin
      ack_o <= busReq;
    end
  end

  // control registers; reserved bits are dropped so they read zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      vertWindowControl <= `VWC_RESET;
      syncSourceSelect <= `SSS_RESET;
    end else if (ce && wrByte0) begin
      if (regIndex == `VWC_IDX) begin
        vertWindowControl <= masked(dat_i[7:0], `VWC_MASK);
      end
      if (regIndex == `SSS_IDX) begin
        syncSourceSelect <= masked(dat_i[7:0], `SSS_MASK);
      end
    end
  end

  // gain set 0 registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mixedSyncGainLow <= `GAIN_LO_RESET;
      lumaGainLow <= `GAIN_LO_RESET;
      uGainLow <= `GAIN_LO_RESET;
      vGainLow <= `GAIN_LO_RESET;
      gainHighBits <= `GAIN_HI_RESET;
      mixedSyncGainHigh <= `MSG_HI_RESET;
    end else if (ce && wrByte0) begin
      case (regIndex)
        `MSG_LO_IDX: mixedSyncGainLow <= dat_i[7:0];
        `YG_LO_IDX: lumaGainLow <= dat_i[7:0];
        `UG_LO_IDX: uGainLow <= dat_i[7:0];
        `VG_LO_IDX: vGainLow <= dat_i[7:0];
        `GAIN_HI_IDX: gainHighBits <= masked(dat_i[7:0], `GAIN_HI_MASK);
        `MSG_HI_IDX: mixedSyncGainHigh <= masked(dat_i[7:0], `MSG_HI_MASK);
        default: ;
      endcase
    end
  end

  // --------
  // vertical interval tracking
  // --------
  sync_window_pkg::vert_state_type vertState;
  logic [4:0] lineCount;

  // window opens after the last equalizing pulse and counts whole lines
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      vertState <= sync_window_pkg::ACTIVE_LINES;
      lineCount <= 5'h00;
    end else if (ce) begin
      case (vertState)
        sync_window_pkg::ACTIVE_LINES: begin
          if (eqDone) begin
            lineCount <= 5'h00;
            // a zero-line window goes straight to the post-window lines
            if (vert_window_lines == 5'h00) begin
              vertState <= sync_window_pkg::POST_WINDOW;
            end else begin
              vertState <= sync_window_pkg::IN_WINDOW;
            end
          end
        end
        sync_window_pkg::IN_WINDOW: begin
          if (vblankEnd) begin
            vertState <= sync_window_pkg::ACTIVE_LINES;
          end else if (lineStart) begin
            if (lineCount + 5'h01 >= vert_window_lines) begin
              vertState <= sync_window_pkg::POST_WINDOW;
            end
            lineCount <= lineCount + 5'h01;
          end
        end
        sync_window_pkg::POST_WINDOW: begin
          if (vblankEnd) begin
            vertState <= sync_window_pkg::ACTIVE_LINES;
          end
        end
        default: vertState <= sync_window_pkg::ACTIVE_LINES;
      endcase
    end
  end

  // --------
  // active gain set and scaling
  // --------
  sync_window_pkg::gain_set_type gainSet0;
  sync_window_pkg::gain_set_type gainActive;

  // high bits sit above the low byte, so msb weights are 2, 4, 2
  assign gainSet0.msync = {mixedSyncGainHigh[1:0], mixedSyncGainLow};
  assign gainSet0.luma =
    {gainHighBits[`GH_Y_MSB:`GH_Y_LSB], lumaGainLow};
  assign gainSet0.u = {gainHighBits[`GH_U_MSB:`GH_U_LSB], uGainLow};
  assign gainSet0.v = {gainHighBits[`GH_V_MSB:`GH_V_LSB], vGainLow};
  // set 0 only while the select pin is low
  assign gainActive = setSelect ? gainSet1 : gainSet0;

  sync_window_pkg::yuv_type scaled;
  logic [9:0] msyncScaled;

  gain_scaler #(.SW(10), .GW(10)) scaleY (
    .sample(combIn.y),
    .gain(gainActive.luma),
    .scaled(scaled.y)
  );

  gain_scaler #(.SW(10), .GW(11)) scaleU (
    .sample(combIn.u),
    .gain(gainActive.u),
    .scaled(scaled.u)
  );

  gain_scaler #(.SW(10), .GW(10)) scaleV (
    .sample(combIn.v),
    .gain(gainActive.v),
    .scaled(scaled.v)
  );

  gain_scaler #(.SW(10), .GW(10)) scaleSync (
    .sample(msyncIn),
    .gain(gainActive.msync),
    .scaled(msyncScaled)
  );

  // --------
  // video output selection
  // --------
  sync_window_pkg::yuv_type next_video;

  // vertical interval lines bypass the gains; active lines are scaled
  always_comb begin
    next_video = scaled;
    case (vertState)
      sync_window_pkg::IN_WINDOW: begin
        if (in_window_action) begin
          next_video.y = rawIn;
          next_video.u = 10'h000;
          next_video.v = 10'h000;
        end else begin
          next_video = simpleIn;
        end
      end
      sync_window_pkg::POST_WINDOW: begin
        if (post_window_action) begin
          next_video = simpleIn;
        end else begin
          next_video = '0;
        end
      end
      default: next_video = scaled;
    endcase
  end

  // one pixel of latency on every video path keeps them aligned
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      videoOut <= '0;
      msyncOut <= 10'h000;
    end else if (ce) begin
      videoOut <= next_video;
      msyncOut <= msyncScaled;
    end
  end

  // --------
  // sync routing
  // --------
  sync_window_pkg::sync_pair_type next_sync;

  // timing source for the sync pulse generator
  always_comb begin
    case (sync_gen_source_sel)
      2'h0: next_sync = extSync;
      2'h1: next_sync = digitizedSync;
      2'h2: next_sync = d1Trs;
      2'h3: next_sync = d2Trs;
      default: next_sync = extSync;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      syncGenOut <= '0;
      sepInput <= 10'h000;
      lineOffset <= 1'b0;
    end else if (ce) begin
      syncGenOut <= next_sync;
      sepInput <= msync_sep_source ? secondaryVideoIn : lpfSyncIn;
      lineOffset <= state_machine_line_offset;
    end
  end

  // --------
  // new field detect delay
  // --------
  logic [`FIELD_DLY_TAPS-2:0] fieldTaps;
  logic next_field;

  // tap 0 is the undelayed pulse; registering adds one fixed cycle
  assign next_field = (field_detect_delay == 2'h0) ? newFieldIn :
                      fieldTaps[field_detect_delay - 2'h1];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fieldTaps <= '0;
      newFieldOut <= 1'b0;
    end else if (ce) begin
      fieldTaps <= {fieldTaps[`FIELD_DLY_TAPS-3:0], newFieldIn};
      newFieldOut <= next_field;
    end
  end

  // --------
  // read data
  // --------
  logic [1:0] stateCode;
  logic [7:0] next_read;

  always_comb begin
    case (vertState)
      sync_window_pkg::IN_WINDOW: stateCode = 2'h1;
      sync_window_pkg::POST_WINDOW: stateCode = 2'h2;
      default: stateCode = 2'h0;
    endcase
  end

  // unmapped addresses read zero
  always_comb begin
    case (regIndex)
      `VWC_IDX: next_read = vertWindowControl;
      `SSS_IDX: next_read = syncSourceSelect;
      `MSG_LO_IDX: next_read = mixedSyncGainLow;
      `YG_LO_IDX: next_read = lumaGainLow;
      `UG_LO_IDX: next_read = uGainLow;
      `VG_LO_IDX: next_read = vGainLow;
      `GAIN_HI_IDX: next_read = gainHighBits;
      `MSG_HI_IDX: next_read = mixedSyncGainHigh;
      `STATUS_IDX: next_read = {setSelect, stateCode, lineCount};
      default: next_read = 8'h00;
    endcase
  end

  // data is captured with the ack so it is valid at the same edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dat_o <= 32'h0000_0000;
    end else if (ce && busReq && !we_i) begin
      dat_o <= {24'h00_0000, next_read};
    end
  end

endmodule : sync_window_regs

// *** sync_window_defs.svh ***
// register offsets, field positions, reset values and timing counts
// Contract
// - window is 0..31 lines after last equalizing pulse
// - in-window: low simple, high raw luma, zero chroma
// - post-window: low blanks YUV, high uses simple decoder
// - frame detect delayed by 0..3 pixels per code; output register adds one more, 1..4
// - generator source: ext, digitized, D1 TRS, D2 TRS
// - separator input: high secondary video, low low-pass output
// - state machine offset: high 1H, low 0H
// - msync gain low byte, lsb weight 1/256
// - luma gain 10 bits, high bits 7-6, msb 2
// - U gain 11 bits, high bits 5-3, msb 4
// - V gain 10 bits, high bits 1-0, msb 2
// - set 0 gains apply only while pin low
// - msync gain high two bits in later register
`ifndef SYNC_WINDOW_DEFS_SVH
`define SYNC_WINDOW_DEFS_SVH

// --------
// register indices (byte address is four times the index)
// --------
`define VWC_IDX 6'h15
`define SSS_IDX 6'h16
`define MSG_LO_IDX 6'h17
`define YG_LO_IDX 6'h18
`define UG_LO_IDX 6'h19
`define VG_LO_IDX 6'h1a
`define GAIN_HI_IDX 6'h1b
`define MSG_HI_IDX 6'h1d
`define STATUS_IDX 6'h30

// --------
// writable bit masks, reserved bits stored and read as zero
// --------
`define VWC_MASK 8'h7f
`define SSS_MASK 8'h3f
`define GAIN_HI_MASK 8'hfb
`define MSG_HI_MASK 8'h03

// --------
// field positions
// --------
`define VWC_LINES_MSB 6
`define VWC_LINES_LSB 2
`define VWC_IN_BIT 1
`define VWC_POST_BIT 0
`define SSS_DLY_MSB 5
`define SSS_DLY_LSB 4
`define SSS_SRC_MSB 3
`define SSS_SRC_LSB 2
`define SSS_SEP_BIT 1
`define SSS_OFS_BIT 0
`define GH_Y_MSB 7
`define GH_Y_LSB 6
`define GH_U_MSB 5
`define GH_U_LSB 3
`define GH_V_MSB 1
`define GH_V_LSB 0

// --------
// reset values: controls off, every gain at unity
// --------
`define VWC_RESET 8'h00
`define SSS_RESET 8'h00
`define GAIN_LO_RESET 8'h00
`define GAIN_HI_RESET 8'h49
`define MSG_HI_RESET 8'h01

// --------
// timing counts
// --------
`define FIELD_DLY_TAPS 4
`define GAIN_FRAC_BITS 8

`endif

// *** sync_window_pkg.sv ***
// shared types of the sync window and gain register block
package sync_window_pkg;

  localparam int SAMPLE_W = 10;

  // one pixel of component video
  typedef struct packed {
    logic [SAMPLE_W-1:0] y;
    logic [SAMPLE_W-1:0] u;
    logic [SAMPLE_W-1:0] v;
  } yuv_type;

  // horizontal and vertical timing marks
  typedef struct packed {
    logic h;
    logic v;
  } sync_pair_type;

  // one full buffered gain set
  typedef struct packed {
    logic [9:0] msync;
    logic [9:0] luma;
    logic [10:0] u;
    logic [9:0] v;
  } gain_set_type;

  // vertical interval position
  typedef enum logic [1:0] {
    ACTIVE_LINES,
    IN_WINDOW,
    POST_WINDOW
  } vert_state_type;

endpackage : sync_window_pkg

// *** gain_scaler.sv ***
// unsigned fixed-point gain applied to one sample, saturating
`timescale 1ns/1ps
`include "sync_window_defs.svh"

module gain_scaler #(
  parameter int SW = 10,
  parameter int GW = 10
) (
  input wire logic [SW-1:0] sample, // sample to scale
  input wire logic [GW-1:0] gain, // gain, lsb weight 1/256
  output logic [SW-1:0] scaled // saturated product
);

  localparam int PW = SW + GW;

  logic [PW-1:0] product;
  logic [PW-1:0] shifted;

  // product drops eight fraction bits so 256 leaves the sample unchanged
  always_comb begin
    product = PW'(sample) * PW'(gain);
    shifted = product >> `GAIN_FRAC_BITS;
    // clip instead of wrap so bright pixels never fold to black
    if (shifted > PW'({SW{1'b1}})) begin
      scaled = {SW{1'b1}};
    end else begin
      scaled = shifted[SW-1:0];
    end
  end

endmodule : gain_scaler

// *** sync_window_monitor.sv ***
// concurrent checks on the sync window and gain register ports
`timescale 1ns/1ps
module sync_window_monitor (
  input wire logic clk, // clock
  input wire logic rstn, // reset, active low
  input wire logic ce, // clock enable
  input wire logic [7:0] adr_i, // byte address
  input wire logic [31:0] dat_i, // write data
  input wire logic [31:0] dat_o, // read data
  input wire logic we_i, // write enable
  input wire logic [3:0] sel_i, // byte selects
  input wire logic cyc_i, // cycle
  input wire logic stb_i, // strobe
  input wire logic ack_o, // acknowledge
  input wire logic regSetSelPin, // set select pin
  input wire logic extHsyncPin, // hsync pin
  input wire logic extVsyncPin, // vsync pin
  input wire sync_window_pkg::sync_pair_type digitizedSync, // digitized
  input wire sync_window_pkg::sync_pair_type d1Trs, // D1 marks
  input wire sync_window_pkg::sync_pair_type d2Trs, // D2 marks
  input wire logic newFieldIn, // frame pulse in
  input wire logic [9:0] secondaryVideoIn, // secondary video
  input wire logic [9:0] lpfSyncIn, // low pass output
  input wire logic [9:0] msyncIn, // mixed sync in
  input wire logic [9:0] msyncOut, // mixed sync out
  input wire logic [9:0] sepInput, // separator input
  input wire sync_window_pkg::sync_pair_type syncGenOut, // generator
  input wire logic newFieldOut, // frame pulse out
  input wire logic lineOffset // 1H offset
);
  // --------
  // shadow registers and history
  // --------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic [5:0] src16;
  logic [7:0] msLo;
  logic [1:0] msHi, up, srcMux, pinPair;
  logic [4:0] nfHist;
  logic [3:0] selHist;
  logic [19:0] msProd;
  logic [9:0] msExp, sepExp;
  logic take, live, srcZero, rdSrc;
  assign take = ce && cyc_i && stb_i && !ack_o && we_i && sel_i[0];
  assign live = (up == 2'd3);
  assign srcZero = (src16[3:2] == 2'd0);
  assign rdSrc = cyc_i && !we_i && adr_i[7:2] == 6'h16;
  assign pinPair = {extHsyncPin, extVsyncPin};
  assign sepExp = src16[1] ? secondaryVideoIn : lpfSyncIn;
  assign msProd = msyncIn * {msHi, msLo};
  assign msExp = (|msProd[19:18]) ? 10'h3ff : msProd[17:8];
  // mirror bus writes, taken on the same edge as the slave
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      src16 <= 6'h00;
      msLo <= 8'h00;
      msHi <= 2'h1;
    end else if (take) begin
      case (adr_i[7:2])
        6'h16: src16 <= dat_i[5:0];
        6'h17: msLo <= dat_i[7:0];
        6'h1d: msHi <= dat_i[1:0];
        default: ;
      endcase
    end
  end
  // warm-up count keeps the live-gated checks off until pipelines hold real data
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      up <= 2'd0;
      nfHist <= 5'h00;
      selHist <= 4'h0;
    end else begin
      up <= up + {1'b0, up != 2'd3};
      nfHist <= {nfHist[3:0], newFieldIn};
      selHist <= {selHist[2:0], regSetSelPin};
    end
  end
  // source mux for the non-pin timing sources
  always_comb begin
    case (src16[3:2])
      2'd1: srcMux = digitizedSync;
      2'd2: srcMux = d1Trs;
      default: srcMux = d2Trs;
    endcase
  end
  // --------
  // properties
  // --------
  property p_ackPulse;
    $rose(ack_o) |=> $fell(ack_o);
  endproperty
  property p_ackAnswer;
    live && ce && cyc_i && stb_i && !ack_o |=> ack_o;
  endproperty
  property p_sepSel;
    live |-> sepInput == $past(sepExp);
  endproperty
  property p_offset;
    live |-> lineOffset == $past(src16[0]);
  endproperty
  property p_syncSrc;
    live |-> syncGenOut ==
      ($past(srcZero) ? $past(pinPair, 3) : $past(srcMux));
  endproperty
  property p_fieldDly;
    live |-> newFieldOut == nfHist[$past(src16[5:4])];
  endproperty
  property p_msync;
    live && selHist == 4'h0 |-> msyncOut == $past(msExp);
  endproperty
  property p_readSrc;
    ack_o && rdSrc |-> dat_o == {26'h000_0000, $past(src16)};
  endproperty
  a_ackPulse: assert property (p_ackPulse)
    else $error("ack held longer than one cycle");
  a_ackAnswer: assert property (p_ackAnswer)
    else $error("request not answered in one cycle");
  a_sepSel: assert property (p_sepSel)
    else $error("separator input source wrong");
  a_offset: assert property (p_offset)
    else $error("line offset output wrong");
  a_syncSrc: assert property (p_syncSrc)
    else $error("sync generator source wrong");
  a_fieldDly: assert property (p_fieldDly)
    else $error("frame detect delay wrong");
  a_msync: assert property (p_msync)
    else $error("mixed sync gain wrong");
  a_readSrc: assert property (p_readSrc)
    else $error("source select readback wrong");
  c_write: cover property (ack_o && we_i);
  c_longDly: cover property (newFieldOut && src16[5:4] == 2'd3);
  c_d2Src: cover property (live && src16[3:2] == 2'd3);
endmodule : sync_window_monitor

bind sync_window_regs sync_window_monitor u_sync_window_monitor (
  .clk, .rstn, .ce, .adr_i, .dat_i, .dat_o, .we_i, .sel_i, .cyc_i,
  .stb_i, .ack_o, .regSetSelPin, .extHsyncPin, .extVsyncPin,
  .digitizedSync, .d1Trs, .d2Trs, .newFieldIn, .secondaryVideoIn,
  .lpfSyncIn, .msyncIn, .msyncOut, .sepInput, .syncGenOut,
  .newFieldOut, .lineOffset);

// *** host_bus_model.sv ***
// host controller model issuing classic wishbone register cycles
`timescale 1ns/1ps
module host_bus_model (
  input wire logic clk, // bus clock
  output logic [7:0] adr, // byte address
  output logic [31:0] dat, // write data
  input wire logic [31:0] datIn, // read data
  output logic we, // write enable
  output logic [3:0] sel, // byte selects
  output logic cyc, // cycle
  output logic stb, // strobe
  input wire logic ack // acknowledge
);
  // idle bus at time zero
  initial begin
    {cyc, stb, we, sel, adr, dat} = '0;
  end
  // writable bits per register; reserved positions always sent as zero
  function automatic logic [7:0] keep(input logic [5:0] idx);
    case (idx)
      6'h15: keep = 8'h7f;
      6'h16: keep = 8'h3f;
      6'h1b: keep = 8'hfb;
      6'h1d: keep = 8'h03;
      default: keep = 8'hff;
    endcase
  endfunction : keep
  // one cycle held until ack; data lines flip after release
  task automatic xfer(input logic w, input logic [5:0] idx,
                      input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    {cyc, stb, we} <= {2'b11, w};
    sel <= 4'h1;
    adr <= {idx, 2'b00};
    dat <= {24'h00_0000, d & keep(idx)};
    do @(posedge clk); while (ack !== 1'b1);
    q = datIn[7:0];
    {cyc, stb, we} <= 3'b000;
    dat <= ~dat;
  endtask : xfer
endmodule : host_bus_model

// *** test_sync_window_and_gain_regs.sv ***
// self-checking bench for the sync window and gain registers
`timescale 1ns/1ps
module test_sync_window_and_gain_regs;
  logic clk = 0;
  logic rstn = 0;
  logic ce;
  logic [7:0] adr, q;
  logic [31:0] datW, datR;
  logic we, cyc, stb, ack, selPin, hPin, vPin, ls, eq, vb, nfIn, nfOut, ofs;
  logic [3:0] sel;
  logic [9:0] secIn, lpfIn, msIn, rawIn, msOut, sepOut;
  sync_window_pkg::sync_pair_type dig, d1, d2, syncOut;
  sync_window_pkg::yuv_type comb, simple, video;
  sync_window_pkg::gain_set_type gs1;
  int bad_count = 0;
  int checks = 0;
  int cycles = 0;
  logic [5:0] ix [8] = '{6'h15, 6'h16, 6'h17, 6'h18, 6'h19, 6'h1a,
                          6'h1b, 6'h1d};
  logic [7:0] rv [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                          8'h49, 8'h01};
  logic [7:0] mk [8] = '{8'h7f, 8'h3f, 8'hff, 8'hff, 8'hff, 8'hff,
                          8'hfb, 8'h03};
  localparam logic [29:0] GAINED = {10'h180, 10'h140, 10'h3ff};
  always #50 clk = ~clk;
  sync_window_regs u_sync_window_regs (
    .clk(clk), .rstn(rstn), .ce(ce), .adr_i(adr), .dat_i(datW),
    .dat_o(datR), .we_i(we), .sel_i(sel), .cyc_i(cyc), .stb_i(stb),
    .ack_o(ack), .regSetSelPin(selPin), .extHsyncPin(hPin),
    .extVsyncPin(vPin), .digitizedSync(dig), .d1Trs(d1), .d2Trs(d2),
    .lineStart(ls), .eqDone(eq), .vblankEnd(vb), .newFieldIn(nfIn),
    .secondaryVideoIn(secIn), .lpfSyncIn(lpfIn), .msyncIn(msIn),
    .combIn(comb), .simpleIn(simple), .rawIn(rawIn), .gainSet1(gs1),
    .videoOut(video), .msyncOut(msOut), .sepInput(sepOut),
    .syncGenOut(syncOut), .newFieldOut(nfOut), .lineOffset(ofs));
  host_bus_model u_host_bus_model (
    .clk(clk), .adr(adr), .dat(datW), .datIn(datR), .we(we), .sel(sel),
    .cyc(cyc), .stb(stb), .ack(ack));
  // --------
  // shared tasks
  // --------
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    u_host_bus_model.xfer(1'b1, i, d, q);
  endtask : wr
  task automatic rd(input logic [5:0] i);
    u_host_bus_model.xfer(1'b0, i, 8'h00, q);
  endtask : rd
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // one-cycle pulse: 0 equalizing end, 1 line start, 2 blanking end
  task automatic pulse(input int w);
    @(posedge clk);
    {eq, ls, vb} <= 3'b100 >> w;
    @(posedge clk);
    {eq, ls, vb} <= 3'b000;
    tick(2);
  endtask : pulse
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  // --------
  // scenarios
  // --------
  task automatic t_regs;
    for (int k = 0; k < 8; k++) begin
      rd(ix[k]);
      chk("reset value", rv[k], q);
    end
    for (int k = 0; k < 8; k++) begin
      wr(ix[k], 8'ha5);
      rd(ix[k]);
      chk("readback", 8'ha5 & mk[k], q);
    end
    wr(6'h20, 8'h5a);
    rd(6'h20);
    chk("unmapped", 8'h00, q);
  endtask : t_regs
  // unity set 1 must win only while the pin is high
  task automatic t_gain;
    wr(6'h17, 8'h40);
    wr(6'h18, 8'h80);
    wr(6'h19, 8'h00);
    wr(6'h1a, 8'h00);
    wr(6'h1b, 8'h62);
    wr(6'h1d, 8'h02);
    tick(3);
    chk("video gained", GAINED, video);
    chk("msync gained", 10'h240, msOut);
    @(posedge clk) selPin <= 1'b1;
    tick(5);
    chk("video set1", comb, video);
    @(posedge clk) selPin <= 1'b0;
    tick(5);
    chk("video set0", GAINED, video);
  endtask : t_gain
  task automatic t_window;
    wr(6'h15, 8'h0a);
    pulse(0);
    chk("in window raw", {rawIn, 20'h0_0000}, video);
    pulse(1);
    chk("window line 1", {rawIn, 20'h0_0000}, video);
    pulse(1);
    chk("post blank", 30'h0000_0000, video);
    pulse(2);
    chk("active", GAINED, video);
    wr(6'h15, 8'h01);
    pulse(0);
    chk("zero window", simple, video);
    pulse(2);
    wr(6'h15, 8'h04);
    pulse(0);
    chk("in window simple", simple, video);
    pulse(2);
  endtask : t_window
  // low enable must keep the window closed through an equalizing pulse
  task automatic t_hold;
    @(posedge clk) ce <= 1'b0;
    pulse(0);
    @(posedge clk) ce <= 1'b1;
    tick(3);
    chk("frozen state", GAINED, video);
  endtask : t_hold
  task automatic t_sync;
    int n;
    logic [1:0] c;
    for (int k = 0; k < 4; k++) begin
      c = k[1:0];
      wr(6'h16, {2'b00, c, c, c[0], ~c[0]});
      tick(4);
      chk("sync source", c ^ 2'b10, syncOut);
      chk("sep input", c[0] ? secIn : lpfIn, sepOut);
      chk("line offset", !c[0], ofs);
      @(posedge clk) nfIn <= 1'b1;
      @(posedge clk) nfIn <= 1'b0;
      n = 1;
      #1;
      while (nfOut !== 1'b1 && n < 8) begin
        tick(1);
        n++;
      end
      chk("field delay", k + 1, n);
    end
  endtask : t_sync
  // cycle ceiling cuts a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      end_of_test();
    end
  end
  // main sequence
  initial begin
    {ce, hPin, selPin, vPin, ls, eq, vb, nfIn} = 8'hc0;
    secIn = 10'h2aa;
    lpfIn = 10'h155;
    msIn = 10'h100;
    rawIn = 10'h155;
    dig = 2'b11;
    d1 = 2'b00;
    d2 = 2'b01;
    comb = {10'h100, 10'h050, 10'h200};
    simple = {10'h123, 10'h045, 10'h067};
    gs1 = {10'h100, 10'h100, 11'h100, 10'h100};
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_gain();
    t_window();
    t_hold();
    t_sync();
    end_of_test();
  end
endmodule : test_sync_window_and_gain_regs
